//--- logic/output_enable_mode_control.sv
// Output enable, shutdown latch and main channel mode control with AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
module output_enable_mode_control #(
  parameter int offMaxCycles = output_ctrl_pkg::TRIG_OFF_MAX_CYC
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic rstn, // Power-up reset
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response, always OKAY
  input wire logic shutdownPin, // Remote shutdown, high active
  input wire logic triggerPin, // Trigger on/off pin level
  input wire logic analogModePin, // High or open selects voltage mode
  input wire logic [4:0] powerupSwitchBank, // Bit 4 is switch five
  input wire logic resetPowerupStrap, // High for a reset power-up
  input wire logic [14:0] savedModeCurrent, // Stored location n at bit n-1
  input wire output_ctrl_pkg::ctrl_src_e nvControlSource, // Stored control source
  input wire logic [11:0] extLimitCode, // Digitised external limit
  output logic powerModulesOn, // Input and output modules run
  output logic outputEnabled, // Output enabled
  output logic outputLedOn, // Output indicator
  output logic faultLedRed, // Fault indicator red
  output logic currentMode, // Main channel in current mode
  output output_ctrl_pkg::off_state_s offState, // Forced settings while off
  output logic remoteSenseFeedback, // Voltage feedback from remote sense
  output logic [11:0] protectVoltCode, // Voltage protect program
  output logic [11:0] protectCurrCode, // Current protect program
  output logic nvSaveStrobe, // One-cycle store request
  output output_ctrl_pkg::ctrl_src_e nvSaveSource // Source being stored
);

  // ==========================================================================
  // Pin synchronisers
  logic [8:0] syncA_reg;
  logic [8:0] syncB_reg;
  logic syncShut;
  logic syncTrig;
  logic syncAnalog;
  logic [4:0] syncSwitch;
  logic syncStrap;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_reg <= 9'h006;
      syncB_reg <= 9'h006;
    end else begin
      syncA_reg <= {resetPowerupStrap, powerupSwitchBank, analogModePin, triggerPin,
                    shutdownPin};
      syncB_reg <= syncA_reg;
    end
  end

  assign syncShut = syncB_reg[0];
  assign syncTrig = syncB_reg[1];
  assign syncAnalog = syncB_reg[2];
  assign syncSwitch = syncB_reg[7:3];
  assign syncStrap = syncB_reg[8];

  // ==========================================================================
  // Pulse qualification
  logic [output_ctrl_pkg::CNT_W-1:0] shutCnt_reg;
  logic [output_ctrl_pkg::CNT_W-1:0] trigCnt_reg;
  logic trigStable_reg;
  logic shutHit;
  logic trigFlip;
  logic trigLowEvent;
  logic trigInverted_reg;
  logic trigOnLevel;

  assign shutHit = syncShut && (shutCnt_reg == output_ctrl_pkg::QUAL_LAST);
  assign trigFlip = (syncTrig != trigStable_reg) && (trigCnt_reg == output_ctrl_pkg::QUAL_LAST);
  assign trigLowEvent = trigFlip && !syncTrig;
  assign trigOnLevel = trigStable_reg ^ trigInverted_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shutCnt_reg <= '0;
    end else if (!syncShut) begin
      shutCnt_reg <= '0;
    end else if (shutCnt_reg != output_ctrl_pkg::QUAL_LAST) begin
      shutCnt_reg <= shutCnt_reg + 12'h001;
    end
  end

  // Open pin reads high, so the filter starts there
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigCnt_reg <= '0;
      trigStable_reg <= 1'b1;
    end else if (syncTrig == trigStable_reg) begin
      trigCnt_reg <= '0;
    end else if (trigFlip) begin
      trigCnt_reg <= '0;
      trigStable_reg <= syncTrig;
    end else begin
      trigCnt_reg <= trigCnt_reg + 12'h001;
    end
  end

  // ==========================================================================
  // Register bus, zero wait states
  logic addrPhase;
  logic dpWrite_reg;
  logic [7:0] dpAddr_reg;
  logic cmdWrite;
  logic [8:0] cmd;
  output_ctrl_pkg::load_type_e loadType_reg;
  output_ctrl_pkg::ctrl_src_e ctrlSrc_reg;
  output_ctrl_pkg::mode_src_e modeSrc_reg;
  output_ctrl_pkg::out_state_e state_reg;
  output_ctrl_pkg::out_state_e stateNext;

  assign addrPhase = hsel && htrans[1] && hready;
  assign cmdWrite = dpWrite_reg && (dpAddr_reg == output_ctrl_pkg::ADDR_CMD);
  assign cmd = cmdWrite ? hwdata[8:0] : 9'h000;

  function automatic logic [31:0] readWord(input logic [7:0] addr);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (addr)
      output_ctrl_pkg::ADDR_CONFIG: word[1:0] = loadType_reg;
      output_ctrl_pkg::ADDR_STATUS: begin
        word[output_ctrl_pkg::ST_OUT_EN] = outputEnabled;
        word[output_ctrl_pkg::ST_SHUT] = (state_reg == output_ctrl_pkg::ST_SHUTDOWN);
        word[output_ctrl_pkg::ST_CURR] = currentMode;
        word[output_ctrl_pkg::ST_INV] = trigInverted_reg;
        word[output_ctrl_pkg::ST_SRC_LO +: 3] = ctrlSrc_reg;
        word[output_ctrl_pkg::ST_MODE_LO +: 3] = modeSrc_reg;
        word[output_ctrl_pkg::ST_TRIG] = trigStable_reg;
      end
      default: word = 32'h0000_0000;
    endcase
    return word;
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dpWrite_reg <= 1'b0;
      dpAddr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dpWrite_reg <= addrPhase && hwrite;
      dpAddr_reg <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        hrdata <= readWord(haddr[7:0]);
      end
    end
  end

  // Encoding 3 is not a load type and is refused
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loadType_reg <= output_ctrl_pkg::LOAD_ACTIVE;
    end else if (dpWrite_reg && (dpAddr_reg == output_ctrl_pkg::ADDR_CONFIG)
                 && (hwdata[1:0] != 2'h3)) begin
      loadType_reg <= output_ctrl_pkg::load_type_e'(hwdata[1:0]);
    end
  end

  // ==========================================================================
  // Start-up strap capture
  logic [2:0] startCnt_reg;
  logic startDone;

  assign startDone = (state_reg == output_ctrl_pkg::ST_INIT)
                     && (startCnt_reg == output_ctrl_pkg::STARTUP_LAST);

  // Lets the synchronisers fill before the straps are believed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      startCnt_reg <= 3'h0;
    end else if (startCnt_reg != output_ctrl_pkg::STARTUP_LAST) begin
      startCnt_reg <= startCnt_reg + 3'h1;
    end
  end

  function automatic output_ctrl_pkg::mode_src_e decodeSwitch(input logic [4:0] sw,
                                                               input logic [14:0] saved);
    output_ctrl_pkg::mode_src_e mode;
    mode = output_ctrl_pkg::MODE_EXT;
    if (sw == 5'h00) begin
      mode = output_ctrl_pkg::MODE_EXT;
    end else if (!sw[4]) begin
      mode = saved[sw[3:0] - 4'h1] ? output_ctrl_pkg::MODE_CURR
                                   : output_ctrl_pkg::MODE_VOLT;
    end else begin
      mode = sw[0] ? output_ctrl_pkg::MODE_VOLT : output_ctrl_pkg::MODE_CURR;
    end
    return mode;
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigInverted_reg <= 1'b0;
    end else if (startDone) begin
      trigInverted_reg <= syncStrap && !syncSwitch[4];
    end
  end

  // ==========================================================================
  // Control source and store
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlSrc_reg <= output_ctrl_pkg::SRC_TOGGLE;
    end else if (startDone) begin
      case (nvControlSource)
        output_ctrl_pkg::SRC_STANDBY: ctrlSrc_reg <= output_ctrl_pkg::SRC_STANDBY;
        output_ctrl_pkg::SRC_COMMAND: ctrlSrc_reg <= output_ctrl_pkg::SRC_COMMAND;
        default: ctrlSrc_reg <= output_ctrl_pkg::SRC_TOGGLE;
      endcase
    end else if (cmd[output_ctrl_pkg::CMD_SRC_COMMAND]) begin
      ctrlSrc_reg <= output_ctrl_pkg::SRC_COMMAND;
    end else if (cmd[output_ctrl_pkg::CMD_SRC_STANDBY]) begin
      ctrlSrc_reg <= output_ctrl_pkg::SRC_STANDBY;
    end else if (cmd[output_ctrl_pkg::CMD_SRC_TOGGLE]) begin
      ctrlSrc_reg <= output_ctrl_pkg::SRC_TOGGLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nvSaveStrobe <= 1'b0;
      nvSaveSource <= output_ctrl_pkg::SRC_TOGGLE;
    end else begin
      nvSaveStrobe <= cmd[output_ctrl_pkg::CMD_SAVE];
      if (cmd[output_ctrl_pkg::CMD_SAVE]) begin
        nvSaveSource <= ctrlSrc_reg;
      end
    end
  end

  // ==========================================================================
  // Output state machine
  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      output_ctrl_pkg::ST_INIT: begin
        if (shutHit) begin
          stateNext = output_ctrl_pkg::ST_SHUTDOWN;
        end else if (startDone) begin
          stateNext = output_ctrl_pkg::ST_OFF;
        end
      end
      output_ctrl_pkg::ST_ON, output_ctrl_pkg::ST_OFF: begin
        if (shutHit) begin
          stateNext = output_ctrl_pkg::ST_SHUTDOWN;
        end else begin
          case (ctrlSrc_reg)
            output_ctrl_pkg::SRC_TOGGLE: begin
              stateNext = trigOnLevel ? output_ctrl_pkg::ST_ON
                                      : output_ctrl_pkg::ST_OFF;
            end
            output_ctrl_pkg::SRC_STANDBY: begin
              if (trigLowEvent || cmd[output_ctrl_pkg::CMD_OUT_OFF]) begin
                stateNext = output_ctrl_pkg::ST_OFF;
              end else if (cmd[output_ctrl_pkg::CMD_OUT_ON]) begin
                stateNext = output_ctrl_pkg::ST_ON;
              end
            end
            default: begin
              if (cmd[output_ctrl_pkg::CMD_OUT_OFF]) begin
                stateNext = output_ctrl_pkg::ST_OFF;
              end else if (cmd[output_ctrl_pkg::CMD_OUT_ON]) begin
                stateNext = output_ctrl_pkg::ST_ON;
              end
            end
          endcase
        end
      end
      output_ctrl_pkg::ST_SHUTDOWN: stateNext = output_ctrl_pkg::ST_SHUTDOWN;
      default: stateNext = output_ctrl_pkg::ST_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= output_ctrl_pkg::ST_INIT;
      outputEnabled <= 1'b0;
      outputLedOn <= 1'b0;
      powerModulesOn <= 1'b0;
      faultLedRed <= 1'b0;
    end else begin
      state_reg <= stateNext;
      outputEnabled <= (stateNext == output_ctrl_pkg::ST_ON);
      outputLedOn <= (stateNext == output_ctrl_pkg::ST_ON);
      powerModulesOn <= (stateNext != output_ctrl_pkg::ST_SHUTDOWN)
                        && (stateNext != output_ctrl_pkg::ST_INIT);
      faultLedRed <= (stateNext == output_ctrl_pkg::ST_SHUTDOWN);
    end
  end

  // ==========================================================================
  // Main channel mode and forced off settings
  logic baseCurrent;
  logic modeIsCurrent;
  logic outputOff;
  output_ctrl_pkg::off_state_s offNext;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modeSrc_reg <= output_ctrl_pkg::MODE_EXT;
    end else if (startDone) begin
      modeSrc_reg <= decodeSwitch(syncSwitch, savedModeCurrent);
    end else if (cmd[output_ctrl_pkg::CMD_MODE_VOLT]) begin
      modeSrc_reg <= output_ctrl_pkg::MODE_VOLT;
    end else if (cmd[output_ctrl_pkg::CMD_MODE_CURR]) begin
      modeSrc_reg <= output_ctrl_pkg::MODE_CURR;
    end else if (cmd[output_ctrl_pkg::CMD_MODE_EXT]) begin
      modeSrc_reg <= output_ctrl_pkg::MODE_EXT;
    end
  end

  assign outputOff = (state_reg != output_ctrl_pkg::ST_ON);
  assign baseCurrent = (modeSrc_reg == output_ctrl_pkg::MODE_CURR)
                       || ((modeSrc_reg == output_ctrl_pkg::MODE_EXT) && !syncAnalog);

  // Resistive keeps the mode; the others force one so the load cannot drive the output
  always_comb begin
    modeIsCurrent = baseCurrent;
    offNext = '0;
    if (outputOff) begin
      offNext.forceZero = 1'b1;
      offNext.limitMax = 1'b1;
      case (loadType_reg)
        output_ctrl_pkg::LOAD_BATTERY: begin
          modeIsCurrent = 1'b1;
          offNext.forceCurrMode = 1'b1;
          offNext.protectMax = 1'b1;
        end
        output_ctrl_pkg::LOAD_RESISTIVE: begin
          offNext.protectMinBox = 1'b1;
        end
        default: begin
          modeIsCurrent = 1'b0;
          offNext.forceVoltMode = 1'b1;
          offNext.protectMax = 1'b1;
        end
      endcase
    end
  end

  function automatic logic [11:0] clampCode(input logic [11:0] code);
    logic [11:0] out;
    out = code;
    if (code < output_ctrl_pkg::CODE_MIN) begin
      out = output_ctrl_pkg::CODE_MIN;
    end
    return out;
  endfunction

  // Protect codes are forced while off; once on, the code for the quantity not regulated is recomputed from extLimitCode and the other set to CODE_MAX
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      currentMode <= 1'b0;
      remoteSenseFeedback <= 1'b1;
      offState <= '0;
      protectVoltCode <= output_ctrl_pkg::CODE_MAX;
      protectCurrCode <= output_ctrl_pkg::CODE_MAX;
    end else begin
      currentMode <= modeIsCurrent;
      remoteSenseFeedback <= !modeIsCurrent;
      offState <= offNext;
      if (offNext.protectMax) begin
        protectVoltCode <= output_ctrl_pkg::CODE_MAX;
        protectCurrCode <= output_ctrl_pkg::CODE_MAX;
      end else if (offNext.protectMinBox) begin
        protectVoltCode <= output_ctrl_pkg::CODE_MIN;
        protectCurrCode <= output_ctrl_pkg::CODE_MIN;
      end else begin
        protectVoltCode <= modeIsCurrent ? clampCode(extLimitCode)
                                         : output_ctrl_pkg::CODE_MAX;
        protectCurrCode <= modeIsCurrent ? output_ctrl_pkg::CODE_MAX
                                         : clampCode(extLimitCode);
      end
    end
  end

  // ==========================================================================
  // Checks
  logic [output_ctrl_pkg::WAIT_W-1:0] offWait_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      offWait_reg <= '0;
    end else if ((ctrlSrc_reg == output_ctrl_pkg::SRC_TOGGLE) && outputEnabled
                 && !(syncTrig ^ trigInverted_reg)) begin
      offWait_reg <= offWait_reg + 23'h000001;
    end else begin
      offWait_reg <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence shutQualified;
    syncShut && (shutCnt_reg == output_ctrl_pkg::QUAL_LAST);
  endsequence

  sequence powerStopped;
    (state_reg == output_ctrl_pkg::ST_SHUTDOWN) && !powerModulesOn && faultLedRed;
  endsequence

  a_shutdown_stops: assert property (shutQualified |=> powerStopped)
    else $error("qualified shutdown did not stop power");
  a_shutdown_held: assert property ((state_reg == output_ctrl_pkg::ST_SHUTDOWN)
    |=> (state_reg == output_ctrl_pkg::ST_SHUTDOWN) && faultLedRed)
    else $error("shutdown latch released");
  a_glitch_rejected: assert property ($rose(faultLedRed)
    |-> $past(shutCnt_reg) == output_ctrl_pkg::QUAL_LAST)
    else $error("shutdown taken before full pulse width");
  a_toggle_follows: assert property ((ctrlSrc_reg == output_ctrl_pkg::SRC_TOGGLE)
    && !outputOff && !shutHit |=> outputEnabled == $past(trigOnLevel))
    else $error("toggle source output does not follow pin");
  a_off_bound: assert property (offWait_reg <= 23'(offMaxCycles))
    else $error("trigger off took too long");
  a_standby_on: assert property ((ctrlSrc_reg == output_ctrl_pkg::SRC_STANDBY)
    && (state_reg == output_ctrl_pkg::ST_OFF) && cmd[output_ctrl_pkg::CMD_OUT_ON]
    && !cmd[output_ctrl_pkg::CMD_OUT_OFF] && !trigLowEvent && !shutHit
    |=> outputEnabled && outputLedOn)
    else $error("standby on command ignored");
  a_command_hold: assert property ((ctrlSrc_reg == output_ctrl_pkg::SRC_COMMAND)
    && (state_reg == output_ctrl_pkg::ST_ON) && !cmd[output_ctrl_pkg::CMD_OUT_OFF] && !shutHit
    |=> outputEnabled)
    else $error("command source output changed without command");
  a_save_source: assert property (cmd[output_ctrl_pkg::CMD_SAVE]
    |=> nvSaveStrobe && (nvSaveSource == $past(ctrlSrc_reg)))
    else $error("save did not store control source");
  a_battery_off: assert property ((state_reg == output_ctrl_pkg::ST_OFF)
    && (loadType_reg == output_ctrl_pkg::LOAD_BATTERY)
    |=> currentMode && offState.protectMax && offState.forceZero)
    else $error("battery off state wrong");
  a_active_off: assert property ((state_reg == output_ctrl_pkg::ST_OFF)
    && (loadType_reg == output_ctrl_pkg::LOAD_ACTIVE)
    |=> !currentMode && offState.forceVoltMode && (protectCurrCode == 12'hfff))
    else $error("active off state wrong");
  a_feedback_select: assert property (##1 remoteSenseFeedback != currentMode)
    else $error("feedback source disagrees with mode");

endmodule // output_enable_mode_control
`default_nettype wire

//--- pkg/output_ctrl_pkg.sv
// Constants, enumerations and carriers for the output enable and mode control block
package output_ctrl_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int PULSE_MIN_NS = 100_000;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TRIG_OFF_MAX_MS = 200;
  localparam int TRIG_OFF_MAX_CYC = TRIG_OFF_MAX_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(PULSE_MIN_CYC - 1);
  localparam logic [2:0] STARTUP_LAST = 3'h3;
  localparam int WAIT_W = 23;

  // ==========================================================================
  // Register map (byte addresses, low eight address bits decoded)
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Command register, write one to act
  localparam int CMD_OUT_ON = 0;
  localparam int CMD_OUT_OFF = 1;
  localparam int CMD_SRC_TOGGLE = 2;
  localparam int CMD_SRC_STANDBY = 3;
  localparam int CMD_SRC_COMMAND = 4;
  localparam int CMD_SAVE = 5;
  localparam int CMD_MODE_VOLT = 6;
  localparam int CMD_MODE_CURR = 7;
  localparam int CMD_MODE_EXT = 8;

  // Status register fields
  localparam int ST_OUT_EN = 0;
  localparam int ST_SHUT = 1;
  localparam int ST_CURR = 2;
  localparam int ST_INV = 3;
  localparam int ST_SRC_LO = 4;
  localparam int ST_MODE_LO = 7;
  localparam int ST_TRIG = 10;

  // ==========================================================================
  // Protection codes
  localparam int CODE_W = 12;
  localparam logic [CODE_W-1:0] CODE_MIN = 12'h199;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;

  // ==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    SRC_TOGGLE = 3'h1,
    SRC_STANDBY = 3'h2,
    SRC_COMMAND = 3'h4
  } ctrl_src_e;

  typedef enum logic [2:0] {
    MODE_VOLT = 3'h1,
    MODE_CURR = 3'h2,
    MODE_EXT = 3'h4
  } mode_src_e;

  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_ON = 4'h2,
    ST_OFF = 4'h4,
    ST_SHUTDOWN = 4'h8
  } out_state_e;

  typedef enum logic [1:0] {
    LOAD_ACTIVE = 2'h0,
    LOAD_RESISTIVE = 2'h1,
    LOAD_BATTERY = 2'h2
  } load_type_e;

  // Forced settings while the output is disabled
  typedef struct packed {
    logic forceZero;
    logic forceVoltMode;
    logic forceCurrMode;
    logic protectMax;
    logic limitMax;
    logic protectMinBox;
  } off_state_s;

endpackage

//--- tb/output_enable_mode_control_bench.sv
// Self-checking bench for the output enable and mode control block
`timescale 1ns/100ps
`default_nettype none
module output_enable_mode_control_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, trigReq = 1'b1, shutReq = 1'b0, modeReq = 1'b1, trg, sht, mde;
  logic powerModulesOn, outputEnabled, outputLedOn, faultLedRed, currentMode, remoteSenseFeedback;
  logic hresp, nvSaveStrobe, strap = 1'b0;
  logic [4:0] switchBank = 5'h10;
  logic [14:0] savedMode = 15'h0000;
  logic [11:0] limCode = 12'h800, protectVoltCode, protectCurrCode;
  int saveCount = 0;
  // The store strobe lasts one cycle, so it is counted as it passes
  always @(posedge clk) begin
    if (nvSaveStrobe === 1'b1) saveCount++;
  end
  output_ctrl_pkg::off_state_s offState;
  output_ctrl_pkg::ctrl_src_e nvSaveSource;
  int errors = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  remote_ctrl_model pin_u (.clk(clk), .trigReq(trigReq), .shutReq(shutReq), .modeReq(modeReq),
    .triggerPin(trg), .shutdownPin(sht), .analogModePin(mde));
  output_enable_mode_control #(.offMaxCycles(2600)) dut_u (.clk(clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .shutdownPin(sht), .triggerPin(trg), .analogModePin(mde), .powerupSwitchBank(switchBank),
    .resetPowerupStrap(strap), .savedModeCurrent(savedMode),
    .nvControlSource(output_ctrl_pkg::SRC_TOGGLE), .extLimitCode(limCode),
    .powerModulesOn(powerModulesOn), .outputEnabled(outputEnabled),
    .outputLedOn(outputLedOn), .faultLedRed(faultLedRed), .currentMode(currentMode),
    .offState(offState), .remoteSenseFeedback(remoteSenseFeedback),
    .protectVoltCode(protectVoltCode), .protectCurrCode(protectCurrCode),
    .nvSaveStrobe(nvSaveStrobe), .nvSaveSource(nvSaveSource));
  // ==========================================================================
  // Tasks
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask
  task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int p;
    int t;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    // Each phase ends at the edge that samples ready high
    for (p = 0; p < 2; p++) begin
      t = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && t < 200) begin
        @(posedge clk);
        t++;
      end
      if (t >= 200) begin
        errors++;
        test_done();
      end
      if (p == 0) begin
        htrans <= 2'h0;
        hwdata <= d;
        hsel <= 1'b0;
      end
    end
    rd = hrdata;
    repeat (3) @(negedge clk);
  endtask
  task cmd(input int b);
    ahb(output_ctrl_pkg::ADDR_CMD, 1'b1, 32'h1 << b);
  endtask
  // Wait bounded well under 200 ms: filter plus sync is about 2503 cycles
  task waitOut(input logic v);
    int i;
    i = 0;
    while (outputEnabled !== v && i < 3000) begin
      @(negedge clk);
      i++;
    end
    chk("outputEnabled", v, outputEnabled);
    chk("outputLedOn", v, outputLedOn);
    if (i >= 3000) test_done();
  endtask
  task pin(input logic v, input int n);
    @(posedge clk) trigReq <= v;
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(negedge clk);
    chk("currentMode", 1, currentMode);
    waitOut(1'b1);
    pin(1'b0, 10);
    waitOut(1'b0);
    $display("test toggle done");
    cmd(output_ctrl_pkg::CMD_SRC_STANDBY);
    pin(1'b1, 2700);
    chk("outputEnabled", 0, outputEnabled);
    cmd(output_ctrl_pkg::CMD_OUT_ON);
    waitOut(1'b1);
    pin(1'b0, 2600);
    pin(1'b1, 10);
    waitOut(1'b0);
    $display("test standby done");
    cmd(output_ctrl_pkg::CMD_SRC_COMMAND);
    pin(1'b0, 2700);
    cmd(output_ctrl_pkg::CMD_OUT_ON);
    waitOut(1'b1);
    cmd(output_ctrl_pkg::CMD_MODE_VOLT);
    chk("currentMode", 0, currentMode);
    chk("protectCurr", 32'h800, protectCurrCode);
    chk("protectVolt", output_ctrl_pkg::CODE_MAX, protectVoltCode);
    chk("remoteSense", 1, remoteSenseFeedback);
    @(posedge clk) modeReq <= 1'b0;
    cmd(output_ctrl_pkg::CMD_MODE_EXT);
    chk("currentMode", 1, currentMode);
    chk("remoteSense", 0, remoteSenseFeedback);
    cmd(output_ctrl_pkg::CMD_OUT_OFF);
    waitOut(1'b0);
    chk("forceVolt", 1, offState.forceVoltMode);
    ahb(output_ctrl_pkg::ADDR_CONFIG, 1'b1, 32'h2);
    chk("forceCurr", 1, offState.forceCurrMode);
    ahb(output_ctrl_pkg::ADDR_CONFIG, 1'b0, 32'h0);
    chk("config", 32'h2, rd);
    ahb(8'h0c, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    cmd(output_ctrl_pkg::CMD_SAVE);
    chk("saveSource", output_ctrl_pkg::SRC_COMMAND, nvSaveSource);
    chk("saveStrobes", 1, saveCount);
    $display("test command done");
    @(posedge clk) shutReq <= 1'b1;
    repeat (2520) @(posedge clk);
    shutReq <= 1'b0;
    repeat (8) @(negedge clk);
    chk("modulesOn", 0, powerModulesOn);
    cmd(output_ctrl_pkg::CMD_OUT_ON);
    chk("faultRed", 1, faultLedRed);
    chk("outputEnabled", 0, outputEnabled);
    $display("test shutdown done");
    chk("hresp", 0, hresp);
    // Power cycle with location 3 saved as current mode and inverted trigger
    @(posedge clk) rstn <= 1'b0;
    switchBank <= 5'h03;
    strap <= 1'b1;
    savedMode <= 15'h0004;
    limCode <= 12'h100;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(negedge clk);
    chk("faultRed", 0, faultLedRed);
    waitOut(1'b1);
    repeat (2) @(negedge clk);
    chk("modulesOn", 1, powerModulesOn);
    chk("currentMode", 1, currentMode);
    chk("protectVolt", output_ctrl_pkg::CODE_MIN, protectVoltCode);
    chk("protectCurr", output_ctrl_pkg::CODE_MAX, protectCurrCode);
    $display("test power cycle done");
    test_done();
  end
endmodule // output_enable_mode_control_bench
`default_nettype wire

//--- tb/remote_ctrl_model.sv
// Remote controller model driving the trigger, shutdown and mode pins
`timescale 1ns/100ps
`default_nettype none
module remote_ctrl_model (
  input wire logic clk, // System clock
  input wire logic trigReq, // Requested trigger level
  input wire logic shutReq, // Requested shutdown level
  input wire logic modeReq, // Requested analog mode level
  output logic triggerPin, // Trigger on/off pin
  output logic shutdownPin, // Remote shutdown pin
  output logic analogModePin // Analog mode pin
);
  // ==========================================================================
  // Pin drive
  // Pins move only at edges, so every pulse is a whole number of cycles
  initial begin
    triggerPin = 1'b1;
    shutdownPin = 1'b0;
    analogModePin = 1'b1;
  end
  always @(posedge clk) begin
    triggerPin <= trigReq;
    shutdownPin <= shutReq;
    analogModePin <= modeReq;
  end
endmodule // remote_ctrl_model
`default_nettype wire
